// ==== freq_source_model.sv ====
// Behavioural tracker, voltage source, blocking matrix and time base.
`timescale 1ns/100ps
module freq_source_model (
	input  wire logic        mclk,
	input  wire logic [15:0] freqSet,
	input  wire logic [15:0] voltSet,
	input  wire logic        blockSet,
	output logic      [15:0] freqRef0 = 16'h1388,
	output logic      [15:0] freqRef1 = 16'h1388,
	output logic      [15:0] freqRef2 = 16'h1388,
	output logic      [15:0] voltMeas = 16'h0000,
	output logic             blockIn = 1'b0,
	output logic      [31:0] timeStamp = 32'h0000_0000
);
	// The second reference stays nominal so that a wrong selection shows up.
	always @(posedge mclk) begin
		freqRef0 <= freqSet;
		freqRef1 <= 16'h1388;
		freqRef2 <= freqSet;
		voltMeas <= voltSet;
		blockIn <= blockSet;
		timeStamp <= timeStamp + 32'h0000_0001;
	end
endmodule // freq_source_model

// ==== freq_stage_regs.vh ====
// Register map, field layout and timing constants of the frequency stage.
// Behaviour
// - Over picks above setting, under below setting.
// - Release only after fixed 20 mHz hysteresis.
// - Ratio of frequency to setting, 0.001 steps.
// - Zero undervoltage threshold disables voltage blocking.
// - Voltage under threshold inhibits stage operation.
// - Stage runs only if group use set.
// - Group and setting changes apply while running.
// - Trip delayed by definite time from start.
// - Condition is normal, start, trip or blocked.
// - Expected operating time readable, 5 ms steps.
// - Signed remaining time while counting, bounded.
// - Block input sampled before pick-up evaluation.
// - Pick-up without block raises start, starts timing.
// - Pick-up with block raises blocked only.
// - Late block clears start like release.
// - Masked time-stamped ON and OFF events.
// - Separately clearable start, trip, blocked counters.
// - Circular log of last twelve operations.
// - Log holds pre-trigger, fault frequency, group.
// - Frequency taken from one of three references.
// - Forcing overrides reported stage condition.
// - Disabled stage gives no outputs or events.
`ifndef FREQ_STAGE_REGS_VH
`define FREQ_STAGE_REGS_VH

`define CLK_MHZ        40
`define PROC_CYCLE_US  5000
`define PROC_CYCLE_MS  5
`define CYCLE_CLKS     (`PROC_CYCLE_US * `CLK_MHZ)
`define PRE_TRIG_MS    20
`define PRE_CYC        (`PRE_TRIG_MS / `PROC_CYCLE_MS)

`define HYST_CNT       16'h0002
`define RATIO_SCALE    32'h0000_03e8
`define RATIO_MAX      16'h4e20
`define DELAY_MAX      20'h5_7e40
`define DIV_STEPS      6'h20
`define LOG_DEPTH      5'h0c
`define LOG_LAST       5'h0b
`define GROUPS         8

`define OFS_CTRL       8'h00
`define OFS_USE        8'h04
`define OFS_FSET_OVER  8'h08
`define OFS_FSET_UNDER 8'h0c
`define OFS_UV_BLOCK   8'h10
`define OFS_DELAY      8'h14
`define OFS_EV_MASK    8'h18
`define OFS_STATUS     8'h1c
`define OFS_RATIO      8'h20
`define OFS_EXP_TIME   8'h24
`define OFS_REM_OVER   8'h28
`define OFS_REM_UNDER  8'h2c
`define OFS_CNT_START  8'h30
`define OFS_CNT_TRIP   8'h34
`define OFS_CNT_BLK    8'h38
`define OFS_LOG_SEL    8'h3c
`define OFS_LOG_TIME   8'h40
`define OFS_LOG_INFO   8'h44
`define OFS_LOG_FREQ   8'h48

`define CTRL_EN_LSB    0
`define CTRL_FRC_EN    2
`define CTRL_FRC_LSB   3
`define CTRL_REF       8:7
`define CTRL_GRP       11:9
`define CTRL_W         12

`define CTRL_RST       12'h000
`define USE_RST        16'h0000
`define FSET_OVER_RST  16'h13ec
`define FSET_UNDER_RST 16'h1324
`define UV_RST         16'h0000
`define DELAY_RST      20'h0_0014
`define EV_MASK_RST    6'h3f

`define COND_NORMAL    2'h0
`define COND_START     2'h1
`define COND_TRIP      2'h2
`define COND_BLOCKED   2'h3

`endif

// ==== frequency_protection_stage.v ====
// Over- and underfrequency protection stage with APB registers, events and fault log.
`timescale 1ns/100ps
`include "freq_stage_regs.vh"

module frequency_protection_stage #(
	parameter [31:0] CYCLE_CLKS = `CYCLE_CLKS,
	parameter        TW         = 18
) (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [15:0] freqRef0,
	input  wire [15:0] freqRef1,
	input  wire [15:0] freqRef2,
	input  wire [15:0] voltMeas,
	input  wire        blockIn,
	input  wire [31:0] timeStamp,
	output reg  [1:0]  startOut,
	output reg  [1:0]  tripOut,
	output reg  [1:0]  blockedOut,
	output reg         evtValid,
	output reg  [11:0] evtFlags,
	output reg  [31:0] evtTime
);

	localparam [TW-1:0] CYC_LAST = CYCLE_CLKS[TW-1:0] - 1'b1;

	reg  [TW-1:0]        tickCnt_q;
	reg                  tick_q;
	reg                  eval_q;
	reg  [`CTRL_W-1:0]   ctrl_q;
	reg  [15:0]          use_q;
	reg  [15:0]          fset_q [0:1];
	reg  [15:0]          uv_q;
	reg  [19:0]          delay_q;
	reg  [5:0]           evMask_q;
	reg  [3:0]           logSel_q;
	reg  [15:0]          freq_q;
	reg  [15:0]          volt_q;
	reg                  blk_q;
	reg  [15:0]          hist_q [0:`PRE_CYC-1];
	reg  [1:0]           pu_q;
	reg  [1:0]           st_q;
	reg  [1:0]           tr_q;
	reg  [1:0]           bl_q;
	reg  [19:0]          cnt_q [0:1];
	reg  [15:0]          cntStart_q;
	reg  [15:0]          cntTrip_q;
	reg  [15:0]          cntBlk_q;
	reg  [31:0]          logTime_q [0:11];
	reg  [5:0]           logInfo_q [0:11];
	reg  [31:0]          logFreq_q [0:11];
	reg  [3:0]           wrPtr_q;
	reg  [3:0]           logCnt_q;
	reg  [1:0]           actV;
	reg  [1:0]           puN;
	reg  [19:0]          cntInc [0:1];
	reg  [3:0]           condV;
	reg  [1:0]           sN;
	reg  [1:0]           tN;
	reg  [1:0]           bN;
	reg  [11:0]          evRaw;
	reg  [2:0]           logId;
	reg  [31:0]          rdData;
	reg                  rdHit;
	reg  [15:0]          refSel;
	wire [31:0]          ratioW;
	wire                 uvBlk;
	wire [2:0]           grp   = ctrl_q[`CTRL_GRP];
	wire                 wrEn  = psel & penable & pwrite;
	wire [3:0]           logIx;
	wire [5:0]           onAll = {evRaw[8:6], evRaw[2:0]};
	wire                 logWr = |onAll;
	integer              i, j, k, m, n;

	function pickFn;
		input        over;
		input        held;
		input [15:0] f;
		input [15:0] s;
		begin
			if (over)
				pickFn = held ? (f > s - `HYST_CNT) : (f > s);
			else
				pickFn = held ? (f < s + `HYST_CNT) : (f < s);
		end
	endfunction

	function [1:0] condFn;
		input b;
		input t;
		input s;
		begin
			condFn = b ? `COND_BLOCKED : t ? `COND_TRIP : s ? `COND_START : `COND_NORMAL;
		end
	endfunction

	function [31:0] remFn;
		input        st;
		input [19:0] d;
		input [19:0] c;
		reg   [20:0] r;
		begin
			r     = {1'b0, d} - {1'b0, c};
			remFn = st ? {{11{r[20]}}, r} : 32'h0000_0000;
		end
	endfunction

	function [3:0] logIdxFn;
		input [3:0] wp;
		input [3:0] n;
		reg   [4:0] v;
		begin
			v = {1'b0, wp} + `LOG_LAST - {1'b0, n};
			if (v >= `LOG_DEPTH) begin
				v = v - `LOG_DEPTH;
			end
			logIdxFn = v[3:0];
		end
	endfunction

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rdHit;
	assign uvBlk   = (uv_q != 16'h0000) && (volt_q < uv_q);
	assign logIx   = logIdxFn(wrPtr_q, logSel_q);

	always @* begin
		case (ctrl_q[`CTRL_REF])
			2'h1:    refSel = freqRef1;
			2'h2:    refSel = freqRef2;
			default: refSel = freqRef0;
		endcase
	end

	// The processing cycle: sample on tick, evaluate one clock later.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tickCnt_q <= {TW{1'b0}};
			tick_q    <= 1'b0;
			eval_q    <= 1'b0;
			freq_q    <= 16'h0000;
			volt_q    <= 16'h0000;
			blk_q     <= 1'b0;
			for (j = 0; j < `PRE_CYC; j = j + 1) begin
				hist_q[j] <= 16'h0000;
			end
		end else begin
			tick_q    <= tickCnt_q == CYC_LAST;
			tickCnt_q <= (tickCnt_q == CYC_LAST) ? {TW{1'b0}} : tickCnt_q + 1'b1;
			eval_q    <= tick_q;
			if (tick_q) begin
				blk_q     <= blockIn;
				freq_q    <= refSel;
				volt_q    <= voltMeas;
				hist_q[0] <= freq_q;
				for (j = 1; j < `PRE_CYC; j = j + 1) begin
					hist_q[j] <= hist_q[j-1];
				end
			end
		end
	end

	always @* begin
		evRaw = 12'h000;
		for (i = 0; i < 2; i = i + 1) begin
			actV[i]   = ctrl_q[`CTRL_EN_LSB + i] & use_q[i*`GROUPS + grp];
			puN[i]    = actV[i] & ~uvBlk & pickFn(i == 0, pu_q[i], freq_q, fset_q[i]);
			cntInc[i] = (cnt_q[i] >= `DELAY_MAX) ? `DELAY_MAX : cnt_q[i] + 20'h0_0001;
			if (!ctrl_q[`CTRL_EN_LSB + i])
				condV[2*i +: 2] = `COND_NORMAL;
			else if (ctrl_q[`CTRL_FRC_EN])
				condV[2*i +: 2] = ctrl_q[`CTRL_FRC_LSB + 2*i +: 2];
			else
				condV[2*i +: 2] = condFn(bl_q[i], tr_q[i], st_q[i]);
			sN[i] = condV[2*i +: 2] == `COND_START || condV[2*i +: 2] == `COND_TRIP;
			tN[i] = condV[2*i +: 2] == `COND_TRIP;
			bN[i] = condV[2*i +: 2] == `COND_BLOCKED;
			evRaw[6*i +: 6] = {bN[i] & ~blockedOut[i], tN[i] & ~tripOut[i], sN[i] & ~startOut[i],
				~bN[i] & blockedOut[i], ~tN[i] & tripOut[i], ~sN[i] & startOut[i]};
			evRaw[6*i +: 6] = {evRaw[6*i +: 3], evRaw[6*i+3 +: 3]};
		end
	end

	// The log keeps one entry per clock; stage 0 and then a trip take precedence.
	always @* begin
		logId = 3'h0;
		for (k = 1; k >= 0; k = k - 1) begin
			if (evRaw[6*k+2])
				logId = {k[0], `COND_BLOCKED};
			if (evRaw[6*k])
				logId = {k[0], `COND_START};
			if (evRaw[6*k+1])
				logId = {k[0], `COND_TRIP};
		end
	end

	// Blocking is seen once per processing cycle, so it must be present at the tick that samples the expiring cycle.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (m = 0; m < 2; m = m + 1) begin
				cnt_q[m] <= 20'h0_0000;
			end
			pu_q <= 2'h0;
			st_q <= 2'h0;
			tr_q <= 2'h0;
			bl_q <= 2'h0;
		end else if (eval_q) begin
			pu_q <= puN;
			for (m = 0; m < 2; m = m + 1) begin
				if (puN[m] & ~blk_q) begin
					st_q[m]  <= 1'b1;
					cnt_q[m] <= cntInc[m];
					tr_q[m]  <= cntInc[m] >= delay_q;
					bl_q[m]  <= 1'b0;
				end else begin
					st_q[m]  <= 1'b0;
					tr_q[m]  <= 1'b0;
					cnt_q[m] <= 20'h0_0000;
					bl_q[m]  <= puN[m];
				end
			end
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			startOut   <= 2'h0;
			tripOut    <= 2'h0;
			blockedOut <= 2'h0;
			evtValid   <= 1'b0;
			evtFlags   <= 12'h000;
			evtTime    <= 32'h0000_0000;
		end else begin
			startOut   <= sN;
			tripOut    <= tN;
			blockedOut <= bN;
			evtValid   <= |(evRaw & {evMask_q, evMask_q});
			evtFlags   <= evRaw & {evMask_q, evMask_q};
			if (|evRaw) begin
				evtTime <= timeStamp;
			end
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_q  <= 4'h0;
			logCnt_q <= 4'h0;
			for (n = 0; n < `LOG_DEPTH; n = n + 1) begin
				logTime_q[n] <= 32'h0000_0000;
				logInfo_q[n] <= 6'h00;
				logFreq_q[n] <= 32'h0000_0000;
			end
		end else if (logWr) begin
			logTime_q[wrPtr_q] <= timeStamp;
			logInfo_q[wrPtr_q] <= {grp, logId};
			logFreq_q[wrPtr_q] <= {hist_q[`PRE_CYC-1], freq_q};
			wrPtr_q  <= ({1'b0, wrPtr_q} == `LOG_LAST) ? 4'h0 : wrPtr_q + 4'h1;
			if ({1'b0, logCnt_q} != `LOG_DEPTH) begin
				logCnt_q <= logCnt_q + 4'h1;
			end
		end
	end

	// A clear that meets a new activation leaves the count at one.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cntStart_q <= 16'h0000;
			cntTrip_q  <= 16'h0000;
			cntBlk_q   <= 16'h0000;
		end else begin
			if (wrEn && paddr == `OFS_CNT_START)
				cntStart_q <= {15'h0000, |onAll[3:0] & (evRaw[0] | evRaw[6])};
			else if (evRaw[0] | evRaw[6])
				cntStart_q <= cntStart_q + 16'h0001;
			if (wrEn && paddr == `OFS_CNT_TRIP)
				cntTrip_q <= {15'h0000, evRaw[1] | evRaw[7]};
			else if (evRaw[1] | evRaw[7])
				cntTrip_q <= cntTrip_q + 16'h0001;
			if (wrEn && paddr == `OFS_CNT_BLK)
				cntBlk_q <= {15'h0000, evRaw[2] | evRaw[8]};
			else if (evRaw[2] | evRaw[8])
				cntBlk_q <= cntBlk_q + 16'h0001;
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q    <= `CTRL_RST;
			use_q     <= `USE_RST;
			fset_q[0] <= `FSET_OVER_RST;
			fset_q[1] <= `FSET_UNDER_RST;
			uv_q      <= `UV_RST;
			delay_q   <= `DELAY_RST;
			evMask_q  <= `EV_MASK_RST;
			logSel_q  <= 4'h0;
		end else if (wrEn) begin
			case (paddr)
				`OFS_CTRL:       ctrl_q    <= pwdata[`CTRL_W-1:0];
				`OFS_USE:        use_q     <= pwdata[15:0];
				`OFS_FSET_OVER:  fset_q[0] <= pwdata[15:0];
				`OFS_FSET_UNDER: fset_q[1] <= pwdata[15:0];
				`OFS_UV_BLOCK:   uv_q      <= pwdata[15:0];
				`OFS_DELAY:      delay_q   <= (pwdata[19:0] > `DELAY_MAX) ? `DELAY_MAX : pwdata[19:0];
				`OFS_EV_MASK:    evMask_q  <= pwdata[5:0];
				`OFS_LOG_SEL:    logSel_q  <= pwdata[3:0];
				default:         logSel_q  <= logSel_q;
			endcase
		end
	end

	always @* begin
		rdHit  = 1'b1;
		rdData = 32'h0000_0000;
		case (paddr)
			`OFS_CTRL:       rdData = {20'h0_0000, ctrl_q};
			`OFS_USE:        rdData = {16'h0000, use_q};
			`OFS_FSET_OVER:  rdData = {16'h0000, fset_q[0]};
			`OFS_FSET_UNDER: rdData = {16'h0000, fset_q[1]};
			`OFS_UV_BLOCK:   rdData = {16'h0000, uv_q};
			`OFS_DELAY:      rdData = {12'h000, delay_q};
			`OFS_EV_MASK:    rdData = {26'h000_0000, evMask_q};
			`OFS_STATUS:     rdData = {24'h00_0000, blk_q, uvBlk, pu_q, condV};
			`OFS_RATIO:      rdData = ratioW;
			`OFS_EXP_TIME:   rdData = {12'h000, delay_q};
			`OFS_REM_OVER:   rdData = remFn(st_q[0], delay_q, cnt_q[0]);
			`OFS_REM_UNDER:  rdData = remFn(st_q[1], delay_q, cnt_q[1]);
			`OFS_CNT_START:  rdData = {16'h0000, cntStart_q};
			`OFS_CNT_TRIP:   rdData = {16'h0000, cntTrip_q};
			`OFS_CNT_BLK:    rdData = {16'h0000, cntBlk_q};
			`OFS_LOG_SEL:    rdData = {28'h000_0000, logSel_q};
			`OFS_LOG_TIME:   rdData = logTime_q[logIx];
			`OFS_LOG_INFO:   rdData = {23'h00_0000, logSel_q < logCnt_q, logInfo_q[logIx][5:3] + 3'h1,
				2'h0, logInfo_q[logIx][2:0]};
			`OFS_LOG_FREQ:   rdData = logFreq_q[logIx];
			default:         rdHit  = 1'b0;
		endcase
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= rdData;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gRatio
			ratio_divider #(
				.QMAX     (`RATIO_MAX)
			) uDiv (
				.mclk     (mclk),
				.sys_rst  (sys_rst),
				.start    (eval_q),
				.dividend (freq_q * `RATIO_SCALE),
				.divisor  (fset_q[g]),
				.quotient (ratioW[16*g +: 16])
			);
		end
	endgenerate

endmodule // frequency_protection_stage

// ==== frequency_protection_stage_checker.sv ====
// Port-level assertions for the frequency protection stage.
`timescale 1ns/100ps
module frequency_protection_stage_checker (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  startOut,
	input wire logic [1:0]  tripOut,
	input wire logic [1:0]  blockedOut,
	input wire logic        evtValid,
	input wire logic [11:0] evtFlags
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_ready_const: assert property (pready) else $error("pready low");
	a_err_access_only: assert property (!(psel && penable) |-> !pslverr) else $error("pslverr outside access");
	a_err_unmapped: assert property (psel && penable && paddr > 8'h48 |-> pslverr) else $error("no pslverr");
	a_rd_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h48 |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_trip_has_start: assert property ((tripOut & ~startOut) == 2'b00) else $error("trip without start");
	a_blocked_no_start: assert property ((blockedOut & startOut) == 2'b00) else $error("blocked with start");
	a_evt_single_pulse: assert property (evtValid |=> !evtValid) else $error("event pulse too long");
	a_evt_has_flag: assert property (evtValid |-> evtFlags != 12'h000) else $error("event without flag");
	a_blocked_stands: assert property ($changed(blockedOut) |=> $stable(blockedOut)[*3])
		else $error("blocked output not held");
endmodule // frequency_protection_stage_checker

bind frequency_protection_stage frequency_protection_stage_checker i_frequency_protection_stage_checker (
	.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .startOut(startOut), .tripOut(tripOut),
	.blockedOut(blockedOut), .evtValid(evtValid), .evtFlags(evtFlags));

// ==== ratio_divider.v ====
// Iterative divider that forms the measured-to-set frequency ratio.
`timescale 1ns/100ps
`include "freq_stage_regs.vh"

module ratio_divider #(
	parameter [15:0] QMAX = `RATIO_MAX
) (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        start,
	input  wire [31:0] dividend,
	input  wire [15:0] divisor,
	output reg  [15:0] quotient
);

	reg  [16:0] rem_q;
	reg  [31:0] quo_q;
	reg  [5:0]  cnt_q;
	wire [16:0] trial = {rem_q[15:0], quo_q[31]};
	wire        fits  = trial >= {1'b0, divisor};
	wire [31:0] quoN  = {quo_q[30:0], fits};

	// A zero setting or a ratio beyond the display range reads as the ceiling.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rem_q    <= 17'h0_0000;
			quo_q    <= 32'h0000_0000;
			cnt_q    <= 6'h00;
			quotient <= 16'h0000;
		end else if (start) begin
			rem_q <= 17'h0_0000;
			quo_q <= dividend;
			cnt_q <= `DIV_STEPS;
		end else if (cnt_q != 6'h00) begin
			rem_q <= fits ? trial - {1'b0, divisor} : trial;
			quo_q <= quoN;
			cnt_q <= cnt_q - 6'h01;
			if (cnt_q == 6'h01) begin
				quotient <= (divisor == 16'h0000 || quoN > {16'h0000, QMAX}) ? QMAX : quoN[15:0];
			end
		end
	end

endmodule // ratio_divider

// ==== tb_frequency_protection_stage.sv ====
// Self-checking bench for the frequency protection stage.
`timescale 1ns/100ps
module tb_frequency_protection_stage;
	localparam int CYC = 40;
	logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, blockSet = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, seed = 32'h64b0, prdata, timeStamp, evtTime;
	logic [15:0] freqSet = 16'h1388, voltSet = 16'h0000, freqRef0, freqRef1, freqRef2, voltMeas;
	logic        pready, pslverr, evtValid, blockIn;
	logic [1:0]  startOut, tripOut, blockedOut;
	logic [11:0] evtFlags;
	logic [32:0] rdq[$];
	logic [27:0] evq[$];
	logic [5:0]  cur = 6'h00, mask = 6'h3f;
	int          n_mismatch = 0, n_tests = 0, gap = 0;

	always #12.5 mclk = ~mclk;

	freq_source_model i_freq_source_model (.mclk(mclk), .freqSet(freqSet), .voltSet(voltSet),
		.blockSet(blockSet), .freqRef0(freqRef0), .freqRef1(freqRef1), .freqRef2(freqRef2),
		.voltMeas(voltMeas), .blockIn(blockIn), .timeStamp(timeStamp));
	frequency_protection_stage #(.CYCLE_CLKS(32'h0000_0028)) i_frequency_protection_stage (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.freqRef0(freqRef0), .freqRef1(freqRef1), .freqRef2(freqRef2), .voltMeas(voltMeas),
		.blockIn(blockIn), .timeStamp(timeStamp), .startOut(startOut), .tripOut(tripOut),
		.blockedOut(blockedOut), .evtValid(evtValid), .evtFlags(evtFlags), .evtTime(evtTime));

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rdq.push_back(e);
		apb(0, a, 32'h0000_0000);
	endtask

	// Outputs are {blocked, trip, start}; a note is kept only if the mask lets an event through.
	task automatic ev(input logic [5:0] n, input int g);
		logic [11:0] f;
		for (int s = 0; s < 2; s++)
			f[6*s +: 6] = {cur[4+s] & ~n[4+s], cur[2+s] & ~n[2+s], cur[s] & ~n[s],
				n[4+s] & ~cur[4+s], n[2+s] & ~cur[2+s], n[s] & ~cur[s]} & mask;
		if (f != 12'h000)
			evq.push_back({g[9:0], f, n});
		cur = n;
	endtask

	task automatic ticks(input int n);
		repeat (n * CYC) @(posedge mclk);
	endtask

	// Sampling at the rising edge sees each output as it stood through the cycle before.
	always @(posedge mclk) begin
		logic [27:0] e;
		gap++;
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, rdq.size() ? rdq.pop_front() : 'x);
		if (evtValid) begin
			e = evq.size() ? evq.pop_front() : 'x;
			check({gap[9:0] & {10{|e[27:18]}}, evtFlags, blockedOut, tripOut, startOut}, e);
			check({1'b0, evtTime}, {1'b0, timeStamp - 32'h0000_0001});
			gap = 0;
		end
	end

	initial begin
		#(25 * 40000);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (20) @(posedge mclk);
		sys_rst <= 0;
		rd(8'h08, 33'h0_0000_13ec);
		rd(8'h0c, 33'h0_0000_1324);
		rd(8'h04, 33'h0_0000_0000);
		rd(8'h10, 33'h0_0000_0000);
		rd(8'h18, 33'h0_0000_003f);
		rd(8'h60, 33'h1_0000_0000);
		apb(1, 8'h14, 32'h0000_0003);
		apb(1, 8'h04, 32'h0000_0101);
		apb(1, 8'h00, 32'h0000_0003);
		rd(8'h24, 33'h0_0000_0003);
		ev(6'h01, 0);
		ev(6'h05, 80);
		voltSet <= 16'($random(seed));
		freqSet <= 16'h13ee + 16'($random(seed) & 32'h0000_00ff);
		ticks(4);
		freqSet <= 16'h13eb;
		ticks(2);
		ev(6'h00, 0);
		freqSet <= 16'h13ea;
		ticks(2);
		ev(6'h10, 0);
		freqSet <= 16'h141e;
		blockSet <= 1;
		ticks(2);
		rd(8'h1c, 33'h0_0000_0093);
		ev(6'h01, 0);
		blockSet <= 0;
		ticks(2);
		ev(6'h10, 0);
		blockSet <= 1;
		ticks(2);
		ev(6'h00, 0);
		blockSet <= 0;
		freqSet <= 16'h1388;
		ticks(2);
		ev(6'h02, 0);
		ev(6'h0a, 80);
		freqSet <= 16'h131a;
		ticks(4);
		freqSet <= 16'h1325;
		ticks(2);
		ev(6'h00, 0);
		freqSet <= 16'h1326;
		ticks(2);
		apb(1, 8'h14, 32'h0000_0014);
		apb(1, 8'h10, 32'h0000_1000);
		voltSet <= 16'h0800;
		freqSet <= 16'h141e;
		ticks(3);
		ev(6'h01, 0);
		voltSet <= 16'h2000;
		ticks(2);
		ev(6'h00, 0);
		voltSet <= 16'h0800;
		ticks(2);
		voltSet <= 16'h2000;
		ev(6'h01, 0);
		do @(posedge mclk); while (evtValid !== 1'b1);
		rd(8'h28, 33'h0_0000_0013);
		rd(8'h2c, 33'h0_0000_0000);
		ticks(1);
		ev(6'h00, 0);
		apb(1, 8'h00, 32'h0000_0083);
		ticks(2);
		ev(6'h01, 0);
		apb(1, 8'h00, 32'h0000_0003);
		ticks(2);
		ev(6'h00, 0);
		apb(1, 8'h00, 32'h0000_0203);
		ticks(2);
		ev(6'h01, 0);
		apb(1, 8'h04, 32'h0000_0303);
		ticks(2);
		ev(6'h00, 0);
		freqSet <= 16'h1388;
		ticks(2);
		rd(8'h30, 33'h0_0000_0007);
		rd(8'h34, 33'h0_0000_0002);
		rd(8'h38, 33'h0_0000_0002);
		apb(1, 8'h34, 32'h0000_0000);
		rd(8'h34, 33'h0_0000_0000);
		rd(8'h20, 33'h0_03fc_03d4);
		rd(8'h30, 33'h0_0000_0007);
		for (int c = 1; c < 5; c++) begin
			ev({1'b0, c[1:0] == 2'd3, 1'b0, c[1:0] == 2'd2, 1'b0, c[1:0] == 2'd1 || c[1:0] == 2'd2}, 0);
			apb(1, 8'h00, 32'h0000_0007 | (32'(c[1:0]) << 3));
			ticks(1);
		end
		apb(1, 8'h00, 32'h0000_0003);
		apb(1, 8'h18, 32'h0000_0038);
		mask = 6'h38;
		ev(6'h01, 0);
		freqSet <= 16'h141e;
		ticks(2);
		rd(8'h44, 33'h0_0000_0121);
		rd(8'h48, 33'h0_1388_141e);
		ev(6'h00, 0);
		freqSet <= 16'h1388;
		ticks(2);
		check(33'(evq.size() + rdq.size()), 33'h0_0000_0000);
		give_verdict();
	end
endmodule // tb_frequency_protection_stage
